/* File: verilog/ras_error_record_syndrome_params.svh */
// Purpose: constants for the error record syndrome block
// Assumes: one error node, record selector zero selects it
// Notes: field positions, codes and reset values live here; select codes and location layout live in the package
//
// Behaviour
// - control bit 0 switches detection and correction
// - feature register is constant read-only 0xA9A2
// - timestamp, critical, injection, postponed irq fields zero
// - overwrite policy 0; overflow raises status flag
// - repeat and other counters both implemented
// - counter width field advertises 8-bit counter
// - three irq fields report enable controls present
// - in-band abort field reads 0b01
// - postpone field zero, detect field 0b10
// - other overflow bit 47 is sticky
// - other counter counts non-matching corrected errors
// - repeat overflow bit 39 is sticky
// - repeat counts first capture and matching errors
// - fault irq when enabled and overflow set
// - location fields need software init before use
// - way field masked per source structure
// - subbank kept only for instruction data errors
// - bank kept for instruction data, mop, level-2
// - word position holds word or doubleword 0-7
// - data tag word position holds bank 0/1
// - coherent slave word position holds error kind
// - bits 18:6 hold failing set index
// - bits 3:0 one-hot detecting unit
// - upper half resets zero, lower half not
// - control bit 8 enables overflow fault irq
`ifndef RAS_ERROR_RECORD_SYNDROME_PARAMS_SVH
`define RAS_ERROR_RECORD_SYNDROME_PARAMS_SVH

// feature register fields and full value
`define FEAT_TS        2'h0
`define FEAT_CI        2'h0
`define FEAT_INJ       2'h0
`define FEAT_CEO       2'h0
`define FEAT_DUI       2'h0
`define FEAT_RP        1'h1
`define FEAT_CEC       3'h2
`define FEAT_CFI       2'h2
`define FEAT_UE        2'h1
`define FEAT_FI        2'h2
`define FEAT_UI        2'h2
`define FEAT_DE        2'h0
`define FEAT_ED        2'h2
`define FEAT_RSVD_W    38
`define FEAT_ID_RESET  64'h0000_0000_0000_A9A2

// control register bits
`define CTL_DETECT_BIT 0
`define CTL_UI_BIT     2
`define CTL_FI_BIT     3
`define CTL_CFI_BIT    8

// syndrome register upper half
`define SYN_OFO_BIT    47
`define SYN_OTH_MSB    46
`define SYN_OTH_LSB    40
`define SYN_OFR_BIT    39
`define SYN_REP_MSB    38
`define SYN_REP_LSB    32
`define SYN_LOC_MSB    31
`define SYN_RSVD_W     16
`define CNT_W          7
`define UPPER_RESET    32'h0000_0000

// detecting unit codes, one-hot
`define UNIT_L1I       4'h1
`define UNIT_TLB       4'h2
`define UNIT_L1D       4'h4
`define UNIT_L2        4'h8

// array codes per unit
`define ARR_L1I_TAG    2'h0
`define ARR_L1I_DATA   2'h1
`define ARR_L1D_DATA   2'h2
`define ARR_L2_TAG     2'h0
`define ARR_L2_CHI     2'h3

`endif

/* File: verilog/ras_error_record_syndrome_pkg.sv */
// Purpose: shared types for the error record syndrome block
// Assumes: constants come from the params header
// Notes: location layout mirrors syndrome bits 31:0
package ras_error_record_syndrome_pkg;

    // register selected by a system register access
    typedef enum logic [1:0] {
        SEL_CONTROL  = 2'h0,
        SEL_FEATURE  = 2'h1,
        SEL_SYNDROME = 2'h2
    } reg_sel_t;

    // one system register request
    typedef struct packed {
        logic        req;
        logic        write;
        reg_sel_t    sel;
        logic [63:0] wdata;
    } reg_req_t;

    // failing RAM location, bits 31:0 of the syndrome
    typedef struct packed {
        logic [3:0]  way;
        logic [1:0]  rsvd;
        logic        subbank;
        logic [1:0]  bank;
        logic [3:0]  wordPos;
        logic [12:0] index;
        logic [1:0]  array;
        logic [3:0]  unit;
    } location_t;

endpackage

/* File: verilog/ras_error_record_syndrome.sv */
// Purpose: error record control, feature and syndrome registers
// Assumes: requests and error reports are on the mclk domain
// Notes: one access per request, answered on the next edge
`timescale 1ns/1ps
`include "ras_error_record_syndrome_params.svh"

module ras_error_record_syndrome #(
    parameter int SEL_W = 16
) (
    // clock and reset
    input  wire logic                                 mclk,
    input  wire logic                                 rst_n,
    // system register access
    input  wire ras_error_record_syndrome_pkg::reg_req_t  regReq,
    input  wire logic [SEL_W-1:0]                     recordSelector,
    output logic                                      regAck,
    output logic [63:0]                               regRdata,
    // corrected error reports from the caches
    input  wire logic                                 ceValid,
    input  wire ras_error_record_syndrome_pkg::location_t ceLoc,
    // controls and interrupt towards the core
    output logic                                      detectEnable,
    output logic                                      faultIrqEnable,
    output logic                                      recoveryIrqEnable,
    output logic                                      faultIrq,
    output logic                                      statusOverflowSet
);

    // constant feature word, built field by field
    localparam logic [63:0] FEATURE_ID = {
        {`FEAT_RSVD_W{1'b0}}, `FEAT_TS, `FEAT_CI, `FEAT_INJ,
        `FEAT_CEO, `FEAT_DUI, `FEAT_RP, `FEAT_CEC, `FEAT_CFI,
        `FEAT_UE, `FEAT_FI, `FEAT_UI, `FEAT_DE, `FEAT_ED
    };

    logic rstMeta_q;
    logic rstSync_q;
    logic selHit;
    logic acc;
    logic ctlWr;
    logic synWr;
    logic detect_q;
    logic ui_q;
    logic fi_q;
    logic cfi_q;
    logic evt;
    logic sameSyn;
    logic bumpRep;
    logic bumpOth;
    logic capture;
    logic recValid_q;
    logic [`CNT_W-1:0] repCnt_q;
    logic [`CNT_W-1:0] othCnt_q;
    logic [`CNT_W-1:0] repBase;
    logic [`CNT_W-1:0] othBase;
    logic [`CNT_W:0]   repSum;
    logic [`CNT_W:0]   othSum;
    logic ofr_q;
    logic ofo_q;
    logic ofrBase;
    logic ofoBase;
    logic ovfPulse_q;
    logic ack_q;
    logic [63:0] rdata_q;
    ras_error_record_syndrome_pkg::location_t cleanLoc;
    ras_error_record_syndrome_pkg::location_t recLoc_q;

    // unused bits of the location are forced to zero per source
    function automatic ras_error_record_syndrome_pkg::location_t cleanLocation(
        input ras_error_record_syndrome_pkg::location_t in
    );
        ras_error_record_syndrome_pkg::location_t o;
        o       = '0;
        o.index = in.index;
        o.array = in.array;
        o.unit  = in.unit;
        case (in.unit)
            `UNIT_L1I: begin
                o.way = {2'h0, in.way[1:0]};
                if (in.array == `ARR_L1I_DATA) begin
                    o.subbank = in.subbank;
                end
                if (in.array != `ARR_L1I_TAG) begin
                    o.bank = in.bank;
                end
            end
            `UNIT_TLB: begin
                o.way = {1'b0, in.way[2:0]};
            end
            `UNIT_L1D: begin
                o.way = {2'h0, in.way[1:0]};
                if (in.array == `ARR_L1D_DATA) begin
                    o.wordPos = {1'b0, in.wordPos[2:0]};
                end else begin
                    o.wordPos = {3'h0, in.wordPos[0]};
                end
            end
            `UNIT_L2: begin
                o.bank = in.bank;
                if (in.array == `ARR_L2_TAG) begin
                    o.way = {1'b0, in.way[2:0]};
                end else if (in.array == `ARR_L2_CHI) begin
                    o.wordPos = {3'h0, in.wordPos[0]};
                end else begin
                    o.wordPos = {1'b0, in.wordPos[2:0]};
                end
            end
            default: begin
                o.way = '0; // not one-hot: keep index and codes only
            end
        endcase
        return o;
    endfunction

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    // access decode: only record zero is implemented here
    assign selHit = (recordSelector == '0);
    assign acc    = regReq.req & selHit;
    assign ctlWr  = acc & regReq.write
                  & (regReq.sel == ras_error_record_syndrome_pkg::SEL_CONTROL);
    assign synWr  = acc & regReq.write
                  & (regReq.sel == ras_error_record_syndrome_pkg::SEL_SYNDROME);

    // control register: reset to off so nothing fires before setup
    always_ff @(posedge mclk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            detect_q <= 1'b0;
            ui_q     <= 1'b0;
            fi_q     <= 1'b0;
            cfi_q    <= 1'b0;
        end else if (ctlWr) begin
            detect_q <= regReq.wdata[`CTL_DETECT_BIT];
            ui_q     <= regReq.wdata[`CTL_UI_BIT];
            fi_q     <= regReq.wdata[`CTL_FI_BIT];
            cfi_q    <= regReq.wdata[`CTL_CFI_BIT];
        end
    end

    assign detectEnable      = detect_q;
    assign faultIrqEnable    = fi_q;
    assign recoveryIrqEnable = ui_q;

    // classify each corrected error against the recorded syndrome
    assign evt      = ceValid & detect_q;
    assign cleanLoc = cleanLocation(ceLoc);
    assign sameSyn  = recValid_q & (cleanLoc == recLoc_q);
    assign capture  = evt & ~recValid_q;
    assign bumpRep  = evt & (~recValid_q | sameSyn);
    assign bumpOth  = evt & recValid_q & ~sameSyn;

    // a software write sets the base, a same-cycle event still counts
    assign repBase = synWr ? regReq.wdata[`SYN_REP_MSB:`SYN_REP_LSB] : repCnt_q;
    assign othBase = synWr ? regReq.wdata[`SYN_OTH_MSB:`SYN_OTH_LSB] : othCnt_q;
    assign ofrBase = synWr ? regReq.wdata[`SYN_OFR_BIT] : ofr_q;
    assign ofoBase = synWr ? regReq.wdata[`SYN_OFO_BIT] : ofo_q;
    assign repSum  = {1'b0, repBase} + {{`CNT_W{1'b0}}, bumpRep};
    assign othSum  = {1'b0, othBase} + {{`CNT_W{1'b0}}, bumpOth};

    // counters and sticky flags; the carry out sets the sticky flag
    always_ff @(posedge mclk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            repCnt_q <= '0;
            othCnt_q <= '0;
            ofr_q    <= 1'b0;
            ofo_q    <= 1'b0;
        end else begin
            repCnt_q <= repSum[`CNT_W-1:0];
            othCnt_q <= othSum[`CNT_W-1:0];
            ofr_q    <= ofrBase | repSum[`CNT_W];
            ofo_q    <= ofoBase | othSum[`CNT_W];
        end
    end

    // status overflow notice, one pulse per wrap
    always_ff @(posedge mclk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            ovfPulse_q <= 1'b0;
        end else begin
            ovfPulse_q <= repSum[`CNT_W] | othSum[`CNT_W];
        end
    end

    assign statusOverflowSet = ovfPulse_q;

    // record-held flag; a software write re-arms the first capture
    always_ff @(posedge mclk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            recValid_q <= 1'b0;
        end else if (capture) begin
            recValid_q <= 1'b1;
        end else if (synWr) begin
            recValid_q <= 1'b0;
        end
    end

    // lower half has no reset, so no reset term here
    always_ff @(posedge mclk) begin
        if (capture) begin
            recLoc_q <= cleanLoc;
        end else if (synWr) begin
            recLoc_q <= regReq.wdata[`SYN_LOC_MSB:0];
        end
    end

    // overflow interrupt holds while enabled and a sticky bit is set
    assign faultIrq = cfi_q & (ofr_q | ofo_q);

    // answer every request; another record reads as zero
    always_ff @(posedge mclk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= regReq.req;
            if (acc && !regReq.write) begin
                case (regReq.sel)
                    ras_error_record_syndrome_pkg::SEL_CONTROL: begin
                        rdata_q <= '0;
                        rdata_q[`CTL_DETECT_BIT] <= detect_q;
                        rdata_q[`CTL_UI_BIT]     <= ui_q;
                        rdata_q[`CTL_FI_BIT]     <= fi_q;
                        rdata_q[`CTL_CFI_BIT]    <= cfi_q;
                    end
                    ras_error_record_syndrome_pkg::SEL_FEATURE: begin
                        rdata_q <= FEATURE_ID;
                    end
                    ras_error_record_syndrome_pkg::SEL_SYNDROME: begin
                        rdata_q <= {{`SYN_RSVD_W{1'b0}}, ofo_q, othCnt_q,
                                    ofr_q, repCnt_q, recLoc_q};
                    end
                    default: begin
                        rdata_q <= '0;
                    end
                endcase
            end else begin
                rdata_q <= '0;
            end
        end
    end

    assign regAck   = ack_q;
    assign regRdata = rdata_q;

    // checks run on the released reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstSync_q);

    sequence s_othAtMax;
        bumpOth && !synWr && (othCnt_q == {`CNT_W{1'b1}});
    endsequence

    sequence s_othWrapped;
        (othCnt_q == '0) && ofo_q && statusOverflowSet;
    endsequence

    sequence s_repAtMax;
        bumpRep && !synWr && (repCnt_q == {`CNT_W{1'b1}});
    endsequence

    sequence s_repWrapped;
        (repCnt_q == '0) && ofr_q && statusOverflowSet;
    endsequence

    a_feature_value: assert property (FEATURE_ID == `FEAT_ID_RESET)
        else $error("feature word differs from reset value");

    a_feature_read: assert property (
        acc && !regReq.write
        && regReq.sel == ras_error_record_syndrome_pkg::SEL_FEATURE
        |=> regAck && regRdata == `FEAT_ID_RESET)
        else $error("feature read returned wrong value");

    a_detect_gate: assert property (
        ceValid && !detect_q && !synWr
        |=> $stable(repCnt_q) && $stable(othCnt_q))
        else $error("counter moved with detection off");

    a_first_capture: assert property (
        capture && !synWr
        |=> recValid_q && recLoc_q == $past(cleanLoc)
            && repCnt_q == $past(repCnt_q) + 7'h01)
        else $error("first error not captured and counted");

    a_other_count: assert property (
        bumpOth && !synWr && othCnt_q != {`CNT_W{1'b1}}
        |=> othCnt_q == $past(othCnt_q) + 7'h01 && $stable(repCnt_q))
        else $error("other counter did not advance by one");

    a_other_wrap: assert property (s_othAtMax |=> s_othWrapped)
        else $error("other counter wrap or sticky wrong");

    a_repeat_wrap: assert property (s_repAtMax |=> s_repWrapped)
        else $error("repeat counter wrap or sticky wrong");

    a_other_sticky: assert property (
        ofo_q && !synWr |=> ofo_q)
        else $error("other overflow flag dropped");

    a_repeat_sticky: assert property (
        ofr_q && !synWr |=> ofr_q)
        else $error("repeat overflow flag dropped");

    a_irq_raise: assert property (
        ctlWr && regReq.wdata[`CTL_CFI_BIT] && (ofo_q || ofr_q) && !synWr
        |=> faultIrq)
        else $error("fault irq missing after enable");

    a_tag_bank: assert property (
        capture && ceLoc.unit == `UNIT_L1D && ceLoc.array != `ARR_L1D_DATA
        |=> recLoc_q.wordPos[3:1] == 3'h0)
        else $error("data tag bank code out of range");

    a_ack_timing: assert property (
        regReq.req |=> regAck)
        else $error("request not answered next cycle");

    a_foreign_zero: assert property (
        regReq.req && !selHit |=> regRdata == 64'h0)
        else $error("other record did not read as zero");

    a_repeat_count: assert property (
        bumpRep && recValid_q && !synWr && repCnt_q != {`CNT_W{1'b1}}
        |=> repCnt_q == $past(repCnt_q) + 7'h01 && $stable(othCnt_q))
        else $error("repeat counter did not advance by one");

    a_control_write: assert property (
        ctlWr
        |=> detect_q == $past(regReq.wdata[`CTL_DETECT_BIT])
            && cfi_q == $past(regReq.wdata[`CTL_CFI_BIT]))
        else $error("control write not applied");

    a_subbank_clear: assert property (
        capture && ceLoc.unit == `UNIT_L1I && ceLoc.array != `ARR_L1I_DATA
        |=> !recLoc_q.subbank)
        else $error("subbank kept for non data source");

endmodule // ras_error_record_syndrome

/* File: verification/test_ras_error_record_syndrome.sv */
// Purpose: self-checking bench for the error record syndrome block
// Assumes: one access per request, answer one edge after it is taken
// Notes: syndrome low half is unknown after reset, so it is written before use
`timescale 1ns/1ps

module test_ras_error_record_syndrome;

    logic                                     mclk;
    logic                                     rst_n;
    ras_error_record_syndrome_pkg::reg_req_t  regReq;
    ras_error_record_syndrome_pkg::location_t ceLoc;
    logic [15:0]                              recordSelector;
    logic                                     ceValid;
    logic                                     regAck;
    logic [63:0]                              regRdata;
    logic                                     detectEnable;
    logic                                     faultIrqEnable;
    logic                                     recoveryIrqEnable;
    logic                                     faultIrq;
    logic                                     statusOverflowSet;
    logic [63:0]                              rd;
    logic [63:0]                              ft;
    logic [31:0]                              locA;
    logic [31:0]                              locB;
    int                                       errorCnt;
    int                                       testsRun;
    int                                       seenPulse;

    // 10 MHz core clock
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    ras_error_record_syndrome #(
        .SEL_W (16)
    ) ras_error_record_syndrome_inst (
        .mclk              (mclk),
        .rst_n             (rst_n),
        .regReq            (regReq),
        .recordSelector    (recordSelector),
        .regAck            (regAck),
        .regRdata          (regRdata),
        .ceValid           (ceValid),
        .ceLoc             (ceLoc),
        .detectEnable      (detectEnable),
        .faultIrqEnable    (faultIrqEnable),
        .recoveryIrqEnable (recoveryIrqEnable),
        .faultIrq          (faultIrq),
        .statusOverflowSet (statusOverflowSet)
    );

    // single place where seen and expected are compared
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // verdict and end of run, also reached from the watchdog
    task automatic completeRun();
        $display("checks %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one register access; request held for exactly the taking edge
    task automatic acc(input logic wr, input logic [1:0] sel, input logic [63:0] wd);
        @(posedge mclk);
        regReq <= '{req: 1'b1, write: wr,
                    sel: ras_error_record_syndrome_pkg::reg_sel_t'(sel), wdata: wd};
        @(posedge mclk);
        regReq.req <= 1'b0;
        #1;
        check("regAck", {63'h0, regAck}, 64'h1);
        rd = regRdata;
    endtask

    // one corrected error report, then count overflow pulses over three cycles
    task automatic ce(input logic [31:0] loc);
        @(posedge mclk);
        ceValid <= 1'b1;
        ceLoc   <= loc;
        @(posedge mclk);
        ceValid <= 1'b0;
        seenPulse = 0;
        repeat (3) begin
            #1;
            if (statusOverflowSet === 1'b1) seenPulse++;
            @(posedge mclk);
        end
    endtask

    // location word with a fixed small index
    function automatic logic [31:0] mk(input logic [3:0] way, input logic sb,
                                       input logic [1:0] bk, input logic [3:0] wp,
                                       input logic [1:0] ar, input logic [3:0] un);
        return {way, 2'h0, sb, bk, wp, 13'h00BC, ar, un};
    endfunction

    // fresh record, one report, expect capture with repeat count one
    task automatic locCase(input logic [31:0] in, input logic [31:0] exp);
        acc(1'b1, 2'h2, 64'h0);
        ce(in);
        acc(1'b0, 2'h2, 64'h0);
        check("location", rd, {32'h0000_0001, exp});
    endtask

    // hang guard, far beyond the roughly 175 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge mclk);
        errorCnt++;
        completeRun();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        regReq = '0;
        recordSelector = 16'h0000;
        ceValid = 1'b0;
        ceLoc = '0;
        errorCnt = 0;
        testsRun = 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check("enables", {61'h0, detectEnable, faultIrqEnable, recoveryIrqEnable}, 64'h0);
        acc(1'b0, 2'h1, 64'h0);
        ft = rd;
        check("feature", ft, 64'h0000_0000_0000_A9A2);
        check("feat_ts_ci_inj", {58'h0, ft[25:20]}, 64'h0);
        check("feat_dui", {62'h0, ft[17:16]}, 64'h0);
        check("feat_ceo", {62'h0, ft[19:18]}, 64'h0);
        check("feat_rp", {63'h0, ft[15]}, 64'h1);
        check("feat_cec", {61'h0, ft[14:12]}, 64'h2);
        check("feat_irqs", {58'h0, ft[11:10], ft[7:6], ft[5:4]}, 64'h2A);
        check("feat_ue", {62'h0, ft[9:8]}, 64'h1);
        check("feat_de_ed", {60'h0, ft[3:0]}, 64'h2);
        check("feat_upper", {26'h0, ft[63:26]}, 64'h0);
        acc(1'b1, 2'h1, 64'hFFFF_FFFF_FFFF_FFFF);
        acc(1'b0, 2'h1, 64'h0);
        check("feature_after_write", rd, 64'h0000_0000_0000_A9A2);
        acc(1'b0, 2'h2, 64'h0);
        check("syndrome_upper_reset", {32'h0, rd[63:32]}, 64'h0);
        acc(1'b0, 2'h0, 64'h0);
        check("control_reset", rd, 64'h0);
        acc(1'b0, 2'h3, 64'h0);
        check("unmapped", rd, 64'h0);
        // another record selected: writes ignored, reads zero
        @(posedge mclk);
        recordSelector <= 16'h0001;
        acc(1'b1, 2'h0, 64'hFFFF_FFFF_FFFF_FFFF);
        acc(1'b0, 2'h1, 64'h0);
        check("other_record_read", rd, 64'h0);
        @(posedge mclk);
        recordSelector <= 16'h0000;
        acc(1'b0, 2'h0, 64'h0);
        check("other_record_write", rd, 64'h0);
        acc(1'b1, 2'h0, 64'hFFFF_FFFF_FFFF_FFFF);
        acc(1'b0, 2'h0, 64'h0);
        check("control_bits", rd, 64'h0000_0000_0000_010D);
        check("enables_on",
              {61'h0, detectEnable, faultIrqEnable, recoveryIrqEnable}, 64'h7);
        check("irq_no_overflow", {63'h0, faultIrq}, 64'h0);
        // detection off: a report leaves no trace
        acc(1'b1, 2'h0, 64'h0);
        acc(1'b1, 2'h2, 64'h0);
        ce(mk(4'h1, 1'b1, 2'h1, 4'h0, 2'h1, 4'h1));
        acc(1'b0, 2'h2, 64'h0);
        check("detect_off", rd, 64'h0);
        acc(1'b1, 2'h0, 64'h1);
        // repeat and other counting
        locA = mk(4'h3, 1'b1, 2'h3, 4'h0, 2'h1, 4'h1);
        locB = mk(4'h2, 1'b0, 2'h1, 4'h0, 2'h1, 4'h1);
        acc(1'b1, 2'h2, 64'h0);
        ce(locA);
        ce(locA);
        ce(locB);
        acc(1'b0, 2'h2, 64'h0);
        check("counts", rd, {32'h0000_0102, locA});
        // per-source cleaning of the location fields
        locCase(mk(4'hF, 1'b1, 2'h3, 4'hF, 2'h1, 4'h1),
                mk(4'h3, 1'b1, 2'h3, 4'h0, 2'h1, 4'h1));
        locCase(mk(4'hF, 1'b1, 2'h3, 4'hF, 2'h0, 4'h1),
                mk(4'h3, 1'b0, 2'h0, 4'h0, 2'h0, 4'h1));
        locCase(mk(4'hF, 1'b1, 2'h3, 4'hF, 2'h2, 4'h1),
                mk(4'h3, 1'b0, 2'h3, 4'h0, 2'h2, 4'h1));
        locCase(mk(4'hF, 1'b1, 2'h3, 4'hF, 2'h0, 4'h2),
                mk(4'h7, 1'b0, 2'h0, 4'h0, 2'h0, 4'h2));
        locCase(mk(4'hF, 1'b1, 2'h3, 4'hF, 2'h2, 4'h4),
                mk(4'h3, 1'b0, 2'h0, 4'h7, 2'h2, 4'h4));
        locCase(mk(4'hF, 1'b1, 2'h3, 4'hF, 2'h0, 4'h4),
                mk(4'h3, 1'b0, 2'h0, 4'h1, 2'h0, 4'h4));
        locCase(mk(4'hF, 1'b1, 2'h3, 4'hF, 2'h1, 4'h8),
                mk(4'h0, 1'b0, 2'h3, 4'h7, 2'h1, 4'h8));
        locCase(mk(4'hF, 1'b1, 2'h3, 4'hF, 2'h3, 4'h8),
                mk(4'h0, 1'b0, 2'h3, 4'h1, 2'h3, 4'h8));
        locCase(mk(4'hF, 1'b1, 2'h3, 4'hF, 2'h1, 4'h3),
                mk(4'h0, 1'b0, 2'h0, 4'h0, 2'h1, 4'h3));
        // repeat counter wrap with interrupt still disabled
        acc(1'b1, 2'h2, 64'h0000_007F_0000_0000);
        ce(locA);
        check("repeat_wrap_pulse", 64'(seenPulse), 64'h1);
        check("irq_disabled", {63'h0, faultIrq}, 64'h0);
        acc(1'b0, 2'h2, 64'h0);
        check("repeat_wrap", rd, {32'h0000_0080, locA});
        acc(1'b1, 2'h0, 64'h0000_0000_0000_0109);
        check("irq_on_repeat", {63'h0, faultIrq}, 64'h1);
        ce(locA);
        acc(1'b0, 2'h2, 64'h0);
        check("repeat_sticky", rd, {32'h0000_0081, locA});
        // clearing by write, then other counter wrap
        acc(1'b1, 2'h2, 64'h0000_7F00_0000_0000);
        check("irq_cleared", {63'h0, faultIrq}, 64'h0);
        ce(locA);
        ce(locB);
        check("other_wrap_pulse", 64'(seenPulse), 64'h1);
        acc(1'b0, 2'h2, 64'h0);
        check("other_wrap", rd, {32'h0000_8001, locA});
        check("irq_on_other", {63'h0, faultIrq}, 64'h1);
        completeRun();
    end

endmodule // test_ras_error_record_syndrome
